// ### dpv_defines.vh
// How it works
// [RL1] Pixel clock 34 to 48.3 MHz, nominal 40, giving 60 Hz refresh.
// [RL2] Frame holds exactly 600 active lines, total 610 to 800 lines.
// [RL3] Line holds exactly 800 active clocks, total 960 to 1150 clocks.
// [RL4] Horizontal and vertical sync outputs are held low always.
// [RL5] Every frame is a whole number of line periods.
// [RL6] Supply stays off at least 500 ms before being reapplied.
// [RL7] With supply off, all link outputs are driven low.
// [RL8] With supply on, all link outputs are actively driven.
// [RL9] Backlight on only after panel runs, off before it stops.
// [RL10] Supply fall should take 10 to 100 ms.
// [RL11] Pixel is three 8-bit fields, bit 7 most significant.
// [RL12] Horizontal reverse strap: low normal, high mirrored.
// [RL13] Vertical reverse strap: low normal, high flipped.
// [RL14] Larger colour values show brighter on the panel.
// [RL15] Data enable high exactly in active clocks, low in blanking.
`ifndef DPV_DEFINES_VH
`define DPV_DEFINES_VH
`define DPV_H_ACTIVE 11'h320
`define DPV_H_TOTAL_MIN 11'h3C0
`define DPV_H_TOTAL_MAX 11'h47E
`define DPV_H_TOTAL_NOM 11'h420
`define DPV_V_ACTIVE 10'h258
`define DPV_V_TOTAL_MIN 10'h262
`define DPV_V_TOTAL_MAX 10'h320
`define DPV_V_TOTAL_NOM 10'h274
`define DPV_CLK_PERIOD_NS 5
`define DPV_OFF_MS 500
`define DPV_BL_GAP_MS 10
`define DPV_MS_CYCLES (1000000 / `DPV_CLK_PERIOD_NS)
`define DPV_DIV_LAST 8'h04
`define DPV_DIV_FALL 8'h01
`define DPV_REG_CTRL 4'h0
`define DPV_REG_GEOM 4'h4
`define DPV_REG_STAT 4'h8
`define DPV_REG_PIX 4'hC
`endif

// ### dpv_host.v
`timescale 1ns/1ps
`include "dpv_defines.vh"
module dpv_host #(
    parameter OFF_CYCLES = `DPV_OFF_MS * `DPV_MS_CYCLES,
    parameter BL_CYCLES = `DPV_BL_GAP_MS * `DPV_MS_CYCLES
) (
    input wire ref_clk,
    input wire reset,
    input wire [3:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [3:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    output reg supply_enable,
    output reg backlight_enable,
    output reg pixel_clock,
    output reg data_enable,
    output reg horizontal_sync_input,
    output reg vertical_sync_input,
    output reg [23:0] pixel_data,
    output reg horizontal_scan_reverse,
    output reg vertical_scan_reverse
);
    // One-hot power states; STAT shows the off state
    localparam ST_OFF = 4'b0001;
    localparam ST_RUN = 4'b0010;
    localparam ST_LIT = 4'b0100;
    localparam ST_DARK = 4'b1000;

    reg [3:0] state;
    reg [31:0] timer;
    reg run_req;
    reg bl_req;
    reg [10:0] h_total;
    reg [9:0] v_total;
    reg [23:0] fill_colour;
    reg [7:0] div_cnt;
    reg [10:0] h_cnt;
    reg [9:0] v_cnt;
    reg [31:0] frame_count;
    reg geom_err;
    // Bus-side capture of one write, address and data apart
    reg aw_held;
    reg w_held;
    reg [3:0] aw_addr;
    reg [31:0] w_data;
    wire link_on;
    wire [10:0] h_clamped;
    wire [10:0] v_clamped;
    wire pix_tick;
    wire active;

    // Clamp a requested total into the legal window
    // Frame totals ride in zero-extended, one bit narrower
    function [10:0] clamp11;
        input [10:0] v;
        input [10:0] lo;
        input [10:0] hi;
        begin
            clamp11 = (v < lo) ? lo : ((v > hi) ? hi : v);
        end
    endfunction

    // Geometry requests pulled into the legal window before storing
    assign h_clamped = clamp11(w_data[10:0], `DPV_H_TOTAL_MIN,
        `DPV_H_TOTAL_MAX); // [RL3]
    assign v_clamped = clamp11({1'b0, w_data[25:16]},
        {1'b0, `DPV_V_TOTAL_MIN}, {1'b0, `DPV_V_TOTAL_MAX}); // [RL2]

    // Write channel capture, either order of address and data
    // Ready pulses for one cycle, so no item is taken twice
    always @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= 4'h0;
            w_data <= 32'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'h0;
        end else begin
            s_axi_awready <= !aw_held && !s_axi_awready && !s_axi_bvalid;
            s_axi_wready <= !w_held && !s_axi_wready && !s_axi_bvalid;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                s_axi_wready <= 1'b0;
            end
            // Answer only once both halves are in
            if (aw_held && w_held) begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (aw_addr == `DPV_REG_STAT) ? 2'h2 : 2'h0;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // Register writes; geometry is clamped so frames stay legal
    always @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            run_req <= 1'b0;
            bl_req <= 1'b0;
            horizontal_scan_reverse <= 1'b0;
            vertical_scan_reverse <= 1'b0;
            h_total <= `DPV_H_TOTAL_NOM;
            v_total <= `DPV_V_TOTAL_NOM;
            fill_colour <= 24'h0;
            geom_err <= 1'b0;
        end else if (aw_held && w_held) begin
            case (aw_addr)
                `DPV_REG_CTRL: begin
                    run_req <= w_data[0];
                    bl_req <= w_data[1];
                    horizontal_scan_reverse <= w_data[2]; // [RL12]
                    vertical_scan_reverse <= w_data[3]; // [RL13]
                end
                `DPV_REG_GEOM: begin
                    h_total <= h_clamped; // [RL3]
                    v_total <= v_clamped[9:0]; // [RL2] [RL5]
                    // Remember that the last request had to be pulled in
                    geom_err <= (h_clamped != w_data[10:0]) ||
                        (v_clamped[9:0] != w_data[25:16]);
                end
                `DPV_REG_PIX: begin
                    fill_colour <= w_data[23:0]; // [RL11] [RL14]
                end
                default: begin
                end
            endcase
        end
    end

    // Read channel, one cycle after the address is taken
    // No new address is taken while an answer waits for rready
    always @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= 2'h0;
        end else begin
            s_axi_arready <= !s_axi_arready && !s_axi_rvalid;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= 2'h0;
                case (s_axi_araddr)
                    `DPV_REG_CTRL: s_axi_rdata <= {28'h0,
                        vertical_scan_reverse, horizontal_scan_reverse,
                        bl_req, run_req};
                    `DPV_REG_GEOM: s_axi_rdata <= {6'h0, v_total,
                        5'h0, h_total};
                    `DPV_REG_STAT: s_axi_rdata <= {frame_count[27:0],
                        geom_err, backlight_enable, supply_enable,
                        state == ST_OFF};
                    `DPV_REG_PIX: s_axi_rdata <= {8'h0, fill_colour};
                    default: begin
                        s_axi_rdata <= 32'h0;
                        s_axi_rresp <= 2'h2;
                    end
                endcase
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // Power and backlight sequencer
    always @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            state <= ST_OFF;
            // A reset may cut a live supply, so the off time restarts
            timer <= OFF_CYCLES; // [RL6]
            supply_enable <= 1'b0;
            backlight_enable <= 1'b0;
        end else begin
            // Timer runs down in every state; zero means elapsed
            if (timer != 32'h0)
                timer <= timer - 32'h1;
            case (state)
                ST_OFF: begin
                    // Off time counts from reset, the supply may be warm
                    if (run_req && timer == 32'h0) begin // [RL6]
                        supply_enable <= 1'b1;
                        timer <= BL_CYCLES;
                        state <= ST_RUN;
                    end
                end
                ST_RUN: begin
                    // Backlight waits until the panel has run a while
                    if (!run_req) begin
                        supply_enable <= 1'b0; // [RL10]
                        timer <= OFF_CYCLES;
                        state <= ST_OFF;
                    end else if (bl_req && timer == 32'h0) begin
                        backlight_enable <= 1'b1; // [RL9]
                        state <= ST_LIT;
                    end
                end
                ST_LIT: begin
                    // Backlight goes dark first, supply drops later
                    if (!run_req || !bl_req) begin
                        backlight_enable <= 1'b0; // [RL9]
                        timer <= BL_CYCLES;
                        state <= ST_DARK;
                    end
                end
                ST_DARK: begin
                    // Panel keeps running through the backlight gap
                    if (timer == 32'h0)
                        state <= ST_RUN;
                end
                default: state <= ST_OFF;
            endcase
        end
    end

    // Link goes quiet on the same edge that drops the supply, never later
    assign link_on = supply_enable && !(state == ST_RUN && !run_req);
    assign pix_tick = (div_cnt == `DPV_DIV_FALL) && pixel_clock;
    assign active = (h_cnt < `DPV_H_ACTIVE) && (v_cnt < `DPV_V_ACTIVE);

    // Divide by five: 40 MHz, two cycles high and three low
    // Even divisors miss the window: by four 50 MHz, by six 33 MHz
    always @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            div_cnt <= 8'h0;
            pixel_clock <= 1'b0;
        end else if (!link_on) begin
            div_cnt <= 8'h0;
            pixel_clock <= 1'b0; // [RL7]
        end else if (div_cnt == `DPV_DIV_LAST) begin
            div_cnt <= 8'h0;
            pixel_clock <= 1'b1; // [RL1] [RL8]
        end else begin
            div_cnt <= div_cnt + 8'h1;
            if (div_cnt == `DPV_DIV_FALL)
                pixel_clock <= 1'b0; // [RL1]
        end
    end

    // Timing counters and link outputs, changed at pixel falling edge
    always @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            h_cnt <= 11'h0;
            v_cnt <= 10'h0;
            frame_count <= 32'h0;
            data_enable <= 1'b0;
            pixel_data <= 24'h0;
            horizontal_sync_input <= 1'b0;
            vertical_sync_input <= 1'b0;
        end else begin
            // Syncs stay low; the panel times itself from data enable
            horizontal_sync_input <= 1'b0; // [RL4]
            vertical_sync_input <= 1'b0; // [RL4]
            if (!link_on) begin
                h_cnt <= 11'h0;
                v_cnt <= 10'h0;
                data_enable <= 1'b0; // [RL7]
                pixel_data <= 24'h0;
            end else if (pix_tick) begin
                data_enable <= active; // [RL15]
                // Blanking carries black, so no stale colour leaks out
                pixel_data <= active ? fill_colour : 24'h0; // [RL11]
                // At or past the end, so a shrunk total cannot run away
                if (h_cnt >= h_total - 11'h1) begin
                    h_cnt <= 11'h0;
                    // Frames end only on line boundaries
                    if (v_cnt >= v_total - 10'h1) begin // [RL5]
                        v_cnt <= 10'h0;
                        frame_count <= frame_count + 32'h1;
                    end else begin
                        v_cnt <= v_cnt + 10'h1;
                    end
                end else begin
                    h_cnt <= h_cnt + 11'h1;
                end
            end
        end
    end
endmodule

// ### dpv_host_checker.sv
`timescale 1ns/1ps
module dpv_host_checker #(
    parameter OFF_CYCLES = 50
) (
    input wire ref_clk,
    input wire reset,
    input wire supply_enable,
    input wire backlight_enable,
    input wire pixel_clock,
    input wire data_enable,
    input wire horizontal_sync_input,
    input wire vertical_sync_input,
    input wire [23:0] pixel_data
);
    reg [31:0] off_cnt;
    reg [10:0] de_cnt;
    reg pclk_q;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);
    // Reset counts as a switch-off, so the off time starts from zero
    always @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            off_cnt <= 32'h0;
            de_cnt <= 11'h000;
            pclk_q <= 1'b0;
        end else begin
            pclk_q <= pixel_clock;
            if (supply_enable)
                off_cnt <= 32'h0;
            else if (off_cnt < OFF_CYCLES)
                off_cnt <= off_cnt + 32'h1;
            if (!data_enable)
                de_cnt <= 11'h000;
            else if (pixel_clock && !pclk_q)
                de_cnt <= de_cnt + 11'h001;
        end
    end
    sync_low_a: assert property (
        !horizontal_sync_input && !vertical_sync_input)
        else $error("sync line driven high");
    off_quiet_a: assert property (
        !supply_enable |-> !pixel_clock && !data_enable && pixel_data == 0)
        else $error("link active while supply off");
    bl_inside_a: assert property (
        backlight_enable |-> supply_enable)
        else $error("backlight on without supply");
    bl_late_a: assert property (
        $rose(backlight_enable) |-> $past(supply_enable, 16))
        else $error("backlight came on too early");
    off_gap_a: assert property (
        $rose(supply_enable) |-> off_cnt >= OFF_CYCLES)
        else $error("supply reapplied too soon");
    clk_period_a: assert property (
        $rose(pixel_clock) |-> ##5 ($rose(pixel_clock) || !supply_enable))
        else $error("pixel clock period wrong");
    line_active_a: assert property (
        $fell(data_enable) && supply_enable |-> de_cnt == 11'h320)
        else $error("active pixel count wrong");
    de_edge_a: assert property (
        $changed(data_enable) && supply_enable |-> $fell(pixel_clock))
        else $error("data enable moved off the falling edge");
    cover property ($rose(backlight_enable));
    cover property ($fell(supply_enable));
    cover property ($fell(data_enable));
endmodule
bind dpv_host dpv_host_checker #(.OFF_CYCLES(OFF_CYCLES)) u_chk (
    .ref_clk(ref_clk), .reset(reset), .supply_enable(supply_enable),
    .backlight_enable(backlight_enable), .pixel_clock(pixel_clock),
    .data_enable(data_enable), .pixel_data(pixel_data),
    .horizontal_sync_input(horizontal_sync_input),
    .vertical_sync_input(vertical_sync_input));

// ### dpv_panel_model.sv
`timescale 1ns/1ps
module dpv_panel_model (
    input wire pixel_clock,
    input wire data_enable,
    input wire horizontal_sync_input,
    input wire vertical_sync_input,
    input wire [23:0] pixel_data,
    input wire horizontal_scan_reverse,
    input wire vertical_scan_reverse,
    output reg [10:0] active_px,
    output reg [10:0] line_clocks,
    output reg [23:0] last_px,
    output wire [1:0] scan_mode,
    output reg sync_bad
);
    reg [10:0] cnt_all = 11'h000;
    reg [10:0] cnt_act = 11'h000;
    reg de_q = 1'b0;
    initial sync_bad = 1'b0;
    // Bit 0 mirrors left-right, bit 1 flips top-bottom
    assign scan_mode = {vertical_scan_reverse, horizontal_scan_reverse};
    // Line timing only from data enable edges; syncs are ignored
    always @(posedge pixel_clock) begin
        de_q <= data_enable;
        if (data_enable && !de_q) begin
            line_clocks <= cnt_all;
            cnt_all <= 11'h001;
            cnt_act <= 11'h001;
        end else begin
            cnt_all <= cnt_all + 11'h001;
            if (data_enable)
                cnt_act <= cnt_act + 11'h001;
        end
        if (!data_enable && de_q)
            active_px <= cnt_act;
        if (data_enable)
            last_px <= pixel_data; // level equals field value
        if (horizontal_sync_input || vertical_sync_input)
            sync_bad <= 1'b1;
    end
endmodule

// ### dpv_host_tb.sv
`timescale 1ns/1ps
`include "dpv_defines.vh"
module dpv_host_tb;
    reg ref_clk, reset, awvalid, wvalid, bready, arvalid, rready;
    reg [3:0] awaddr, araddr;
    reg [31:0] wdata;
    wire awready, wready, bvalid, arready, rvalid, sup, bl, pclk, de, hs, vs;
    wire hrev, vrev, sync_bad;
    wire [1:0] bresp, rresp, scan_mode;
    wire [31:0] rdata;
    wire [23:0] pix, last_px;
    wire [10:0] active_px, line_clocks;
    int err_total, checks_done, k, gap;
    logic [31:0] rd;
    dpv_host #(.OFF_CYCLES(50), .BL_CYCLES(20)) i_dut (
        .ref_clk(ref_clk), .reset(reset), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .supply_enable(sup), .backlight_enable(bl),
        .pixel_clock(pclk), .data_enable(de), .horizontal_sync_input(hs),
        .vertical_sync_input(vs), .pixel_data(pix),
        .horizontal_scan_reverse(hrev), .vertical_scan_reverse(vrev));
    dpv_panel_model i_panel (
        .pixel_clock(pclk), .data_enable(de), .horizontal_sync_input(hs),
        .vertical_sync_input(vs), .pixel_data(pix),
        .horizontal_scan_reverse(hrev), .vertical_scan_reverse(vrev),
        .active_px(active_px), .line_clocks(line_clocks),
        .last_px(last_px), .scan_mode(scan_mode), .sync_bad(sync_bad));
    initial begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end
    // Length of the latest supply-off stretch, in clock cycles
    always @(posedge ref_clk)
        gap <= sup ? 0 : gap + 1;
    task complete_run;
        $display("checks %0d errors %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task give_up(input string what);
        chk(what, 32'h1, 32'h0);
        complete_run;
    endtask
    // Address and data offered together, each dropped once taken
    task axi_wr(input [3:0] a, input [31:0] d, input [1:0] er);
        @(posedge ref_clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        k = 0;
        do begin
            @(posedge ref_clk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            k++;
        end while (!bvalid && k < 100);
        bready <= 1'b0;
        if (k >= 100) give_up("write wait");
        chk("bresp", {30'h0, er}, {30'h0, bresp});
    endtask
    task axi_rd(input [3:0] a, input [1:0] er, output logic [31:0] d);
        @(posedge ref_clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        k = 0;
        do begin
            @(posedge ref_clk);
            if (arvalid && arready) arvalid <= 1'b0;
            k++;
        end while (!rvalid && k < 100);
        d = rdata;
        rready <= 1'b0;
        if (k >= 100) give_up("read wait");
        chk("rresp", {30'h0, er}, {30'h0, rresp});
    endtask
    initial begin
        {reset, awvalid, wvalid, bready, arvalid, rready} = 6'h20;
        {awaddr, araddr, wdata} = 40'h0;
        err_total = 0;
        checks_done = 0;
        repeat (2) @(posedge ref_clk);
        reset <= 1'b0;
        axi_rd(`DPV_REG_CTRL, 2'b00, rd);
        chk("ctrl", 32'h0, rd);
        axi_rd(`DPV_REG_GEOM, 2'b00, rd);
        chk("geom", 32'h0274_0420, rd);
        axi_wr(`DPV_REG_STAT, 32'hF, 2'b10);
        axi_rd(4'h2, 2'b10, rd);
        chk("unmapped", 32'h0, rd);
        axi_wr(`DPV_REG_GEOM, 32'h0, 2'b00);
        axi_rd(`DPV_REG_GEOM, 2'b00, rd);
        chk("geom low", 32'h0262_03C0, rd);
        axi_wr(`DPV_REG_GEOM, 32'h03FF_07FF, 2'b00);
        axi_rd(`DPV_REG_GEOM, 2'b00, rd);
        chk("geom high", 32'h0320_047E, rd);
        axi_rd(`DPV_REG_STAT, 2'b00, rd);
        chk("clamp flag", 32'h8, rd & 32'h8);
        axi_wr(`DPV_REG_GEOM, 32'h0262_03C0, 2'b00);
        axi_wr(`DPV_REG_PIX, 32'h00A5_5AFF, 2'b00);
        axi_wr(`DPV_REG_CTRL, 32'hF, 2'b00);
        // Two data enable rises are needed before a line length exists
        for (k = 0; k < 40000 && line_clocks !== 11'h3C0; k++)
            @(posedge ref_clk);
        chk("line", 32'h3C0, {21'h0, line_clocks});
        chk("active", 32'h320, {21'h0, active_px});
        chk("pixel", 32'h00A5_5AFF, {8'h0, last_px});
        chk("scan", 32'h3, {30'h0, scan_mode});
        chk("sync", 32'h0, {31'h0, sync_bad});
        axi_rd(`DPV_REG_STAT, 2'b00, rd);
        chk("stat", 32'h6, rd & 32'hE);
        axi_wr(`DPV_REG_CTRL, 32'h5, 2'b00);
        chk("scan h", 32'h1, {30'h0, scan_mode});
        axi_wr(`DPV_REG_CTRL, 32'h0, 2'b00);
        for (k = 0; k < 500 && sup; k++)
            @(posedge ref_clk);
        axi_wr(`DPV_REG_CTRL, 32'h1, 2'b00);
        for (k = 0; k < 500 && !sup; k++)
            @(posedge ref_clk);
        chk("supply", 32'h1, {31'h0, sup});
        chk("gap", 32'h1, {31'h0, gap >= 50});
        complete_run;
    end
endmodule
